// ==== ctb_tx_bank.sv ====
// three can transmit buffers with apb registers and error counter
//
// How it works
// R1 - setting send request starts transmit and clears aborted, lost, error bits
// R2 - send request clears itself after a successful frame
// R3 - buffer registers ignore writes while send request is set
// R4 - clearing a set send request aborts the pending frame
// R5 - aborted bit set on abort, clear otherwise
// R6 - lost arbitration bit set when the frame loses arbitration
// R7 - bus error bit set when an error hits the frame
// R8 - done flag set after success in enhanced mode, reads zero in legacy
// R9 - two bit priority, 00 lowest, 11 highest, read and write
// R10 - priority only orders buffers, never alters the identifier
// R11 - three buffers, each with eight payload bytes
// R12 - identifier high byte gives std bits 10..3 or ext bits 28..21
// R13 - low byte bits 7..5 give std 2..0 or ext 20..18, bits 1..0 ext 17..16
// R14 - extended select picks 29 bit frame, else ext bits 17..0 ignored
// R15 - two ext bytes carry ext bits 15..0, unused for standard frames
// R16 - remote select bit drives the frame remote request bit
// R17 - length codes 0..8 give payload length, 9..15 reserved
// R18 - read only 8 bit error counter, overflow enters bus off
// R19 - 128 runs of 11 recessive bits clear the error counter
// R20 - unimplemented control, id low and length bits read zero
// R21 - software requests only in normal or loopback mode; this design has no modes and accepts requests at any time
// R22 - equal priority goes to the highest buffer number
// R23 - control, status and counter reset to zero
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module ctb_tx_bank
    import ctb_pkg::*;
#(
    parameter logic [7:0] TEC_STEP = TEC_STEP_DEF,
    parameter logic [7:0] REC_OCC = REC_CLEAR_CNT
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    output logic o_tx_valid,
    output ctb_frame_t o_tx_frame,
    output logic [1:0] o_tx_buf,
    output logic o_tx_abort,
    input wire logic i_tx_start,
    input wire logic i_tx_ok,
    input wire logic i_tx_arb_lost,
    input wire logic i_tx_bus_err,
    input wire logic i_tec_inc,
    input wire logic i_tec_dec,
    input wire logic i_rec11,
    output logic o_bus_off,
    output logic [7:0] o_tec
);

    ctb_state_t q;
    ctb_state_t d;
    logic [1:0] bsel;
    logic [3:0] widx;
    logic glob;
    logic hit;
    logic setup;
    logic acc;
    logic wr;
    logic [7:0] rd;
    logic [7:0] wb;
    logic [2:0] pick;
    logic [8:0] tsum;
    ctb_buf_t b;

    // R12 R13 R14 R15 R16 R10 - identifier built from id bytes only
    function automatic ctb_frame_t mk_frame(input ctb_buf_t x);
        ctb_frame_t f;
        f.ext = x.sidl[B_EXT];
        f.rtr = x.dlc[B_RTR];
        f.dlc = x.dlc[3:0];
        f.data = x.data;
        if (x.sidl[B_EXT]) begin
            f.id = {x.sidh, x.sidl[7:5], x.sidl[1:0], x.eidh, x.eidl};
        end else begin
            f.id = {18'h00000, x.sidh, x.sidl[7:5]};
        end
        return f;
    endfunction : mk_frame

    // R22 R9 - best priority, ties to higher number
    function automatic logic [2:0] sel_buf(input ctb_buf_t [NBUF-1:0] v);
        logic found;
        logic [1:0] idx;
        logic [1:0] best;
        found = 1'b0;
        idx = 2'h0;
        best = 2'h0;
        for (int n = 0; n < NBUF; n++) begin
            if (v[n].req && !v[n].abt_pend && (!found || v[n].pri >= best)) begin
                found = 1'b1;
                idx = n[1:0];
                best = v[n].pri;
            end
        end
        return {found, idx};
    endfunction : sel_buf

    always_comb begin
        d = q;
        bsel = i_paddr[7:6];
        widx = i_paddr[5:2];
        glob = (bsel == GLOB_SLOT);
        hit = 1'b0;
        rd = 8'h00;
        wb = i_pwdata[7:0];
        b = q.bufs[0];
        setup = i_psel && !i_penable;
        acc = i_psel && i_penable && q.pready;
        tsum = 9'h000;
        if (!glob) begin
            b = q.bufs[bsel];
            hit = 1'b1;
            case (widx)
                // R8 R20 - done flag gated by mode, bit 2 zero
                W_CTRL: rd = {b.irq & q.enh, b.abt, b.larb, b.err, b.req, 1'b0, b.pri};
                W_SIDH: rd = b.sidh;
                // R20 - unimplemented bits read zero
                W_SIDL: rd = b.sidl & SIDL_MASK;
                W_EIDH: rd = b.eidh;
                W_EIDL: rd = b.eidl;
                W_DLC: rd = b.dlc & DLC_MASK;
                default: begin
                    // R11 - eight payload bytes
                    if (widx[3]) begin
                        rd = b.data[widx[2:0]];
                    end else begin
                        hit = 1'b0;
                    end
                end
            endcase
        end else begin
            hit = 1'b1;
            case (widx)
                // R18 - counter read only
                W_TEC: rd = q.tec;
                W_CFG: rd = {7'h00, q.enh};
                W_STAT: rd = {7'h00, q.bus_off};
                default: hit = 1'b0;
            endcase
        end
        hit = hit && (i_paddr[AW-1:8] == '0) && (i_paddr[1:0] == 2'h0);
        d.pready = setup;
        d.pslverr = setup && !hit;
        d.prdata = setup ? {24'h000000, rd} : 32'h00000000;
        wr = acc && i_pwrite && !q.pslverr && i_pstrb[0];

        if (wr && !glob) begin
            if (widx == W_CTRL) begin
                if (!wb[B_IRQ]) begin
                    d.bufs[bsel].irq = 1'b0;
                end
                if (!q.bufs[bsel].req) begin
                    // R9 - priority writable while idle
                    d.bufs[bsel].pri = wb[1:0];
                    if (wb[B_REQ]) begin
                        // R1 - request clears status bits
                        d.bufs[bsel].req = 1'b1;
                        d.bufs[bsel].abt = 1'b0;
                        d.bufs[bsel].larb = 1'b0;
                        d.bufs[bsel].err = 1'b0;
                    end
                end else if (!wb[B_REQ]) begin
                    // R4 - abort now, or after the frame in flight
                    if (q.st != ST_IDLE && q.cur == bsel) begin
                        d.bufs[bsel].abt_pend = 1'b1;
                    end else begin
                        d.bufs[bsel].req = 1'b0;
                        d.bufs[bsel].abt = 1'b1;
                    end
                end
            end else if (!q.bufs[bsel].req) begin
                // R3 - locked while request set
                case (widx)
                    W_SIDH: d.bufs[bsel].sidh = wb;
                    W_SIDL: d.bufs[bsel].sidl = wb & SIDL_MASK;
                    W_EIDH: d.bufs[bsel].eidh = wb;
                    W_EIDL: d.bufs[bsel].eidl = wb;
                    // R17 - code stored as written
                    W_DLC: d.bufs[bsel].dlc = wb & DLC_MASK;
                    default: d.bufs[bsel].data[widx[2:0]] = wb;
                endcase
            end
        end
        if (wr && glob && widx == W_CFG) begin
            d.enh = wb[B_ENH];
        end

        pick = sel_buf(d.bufs);
        unique case (q.st)
            ST_IDLE: begin
                if (pick[2] && !q.bus_off) begin
                    d.cur = pick[1:0];
                    d.st = ST_OFFER;
                end
            end
            ST_OFFER: begin
                if (i_tx_start) begin
                    d.st = ST_BUSY;
                end else if (d.bufs[q.cur].abt_pend) begin
                    // R5 - abort before start
                    d.bufs[q.cur].abt_pend = 1'b0;
                    d.bufs[q.cur].req = 1'b0;
                    d.bufs[q.cur].abt = 1'b1;
                    d.st = ST_IDLE;
                end else if (q.bus_off) begin
                    d.st = ST_IDLE;
                end
            end
            ST_BUSY: begin
                if (i_tx_ok) begin
                    // R2 - success clears request
                    d.bufs[q.cur].req = 1'b0;
                    d.bufs[q.cur].abt_pend = 1'b0;
                    // R8 - done flag, set wins over clear
                    if (q.enh) begin
                        d.bufs[q.cur].irq = 1'b1;
                    end
                    d.st = ST_IDLE;
                end else if (i_tx_arb_lost || i_tx_bus_err) begin
                    // R6 - lost arbitration
                    if (i_tx_arb_lost) begin
                        d.bufs[q.cur].larb = 1'b1;
                    end
                    // R7 - bus error
                    if (i_tx_bus_err) begin
                        d.bufs[q.cur].err = 1'b1;
                    end
                    // R5 - abort after failed attempt
                    if (d.bufs[q.cur].abt_pend) begin
                        d.bufs[q.cur].abt_pend = 1'b0;
                        d.bufs[q.cur].req = 1'b0;
                        d.bufs[q.cur].abt = 1'b1;
                    end
                    d.st = ST_IDLE;
                end
            end
        endcase

        // R18 - counter overflow enters bus off
        if (i_tec_inc) begin
            tsum = {1'b0, q.tec} + {1'b0, TEC_STEP};
            if (tsum[8]) begin
                d.tec = 8'hff;
                d.bus_off = 1'b1;
            end else begin
                d.tec = tsum[7:0];
            end
        end else if (i_tec_dec && q.tec != 8'h00 && !q.bus_off) begin
            d.tec = q.tec - 8'h01;
        end
        // R19 - recessive runs clear the counter
        if (q.bus_off && i_rec11) begin
            if (q.rec_cnt == REC_OCC - 8'h01) begin
                d.rec_cnt = 8'h00;
                d.tec = 8'h00;
                d.bus_off = 1'b0;
            end else begin
                d.rec_cnt = q.rec_cnt + 8'h01;
            end
        end

        d.tx_valid = (d.st == ST_OFFER);
        d.tx_abort = (d.st == ST_BUSY) && d.bufs[d.cur].abt_pend;
        d.frame = mk_frame(d.bufs[d.cur]);

        // R23 - control and counter cleared
        if (i_rst) begin
            d = '0;
            d.st = ST_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        q <= d;
    end

    assign o_pready = q.pready;
    assign o_prdata = q.prdata;
    assign o_pslverr = q.pslverr;
    assign o_tx_valid = q.tx_valid;
    assign o_tx_frame = q.frame;
    assign o_tx_buf = q.cur;
    assign o_tx_abort = q.tx_abort;
    assign o_bus_off = q.bus_off;
    assign o_tec = q.tec;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_wr0;
        i_psel && i_penable && q.pready && i_pwrite && !q.pslverr && i_pstrb[0]
            && i_paddr == 12'h000;
    endsequence
    sequence s_busy_end;
        q.st == ST_BUSY && i_tx_ok;
    endsequence

    property p_req_set;
        s_wr0 and (i_pwdata[B_REQ] && !q.bufs[0].req)
            |=> q.bufs[0].req && !q.bufs[0].abt && !q.bufs[0].larb;
    endproperty
    a_req_set: assert property (p_req_set) else $error("request did not clear status"); // R1

    property p_ok_clears;
        s_busy_end |=> !q.bufs[$past(q.cur)].req ##1 q.st != ST_BUSY;
    endproperty
    a_ok_clears: assert property (p_ok_clears) else $error("request kept after success"); // R2

    property p_locked;
        q.bufs[0].req && !i_tx_ok |=> $stable(q.bufs[0].sidh) && $stable(q.bufs[0].dlc);
    endproperty
    a_locked: assert property (p_locked) else $error("locked buffer changed"); // R3

    property p_abort_idle;
        i_psel && i_penable && q.pready && i_pwrite && !q.pslverr && i_pstrb[0]
            && i_paddr == 12'h040 && !i_pwdata[B_REQ] && q.bufs[1].req
            && (q.st == ST_IDLE || q.cur != 2'h1)
            |=> !q.bufs[1].req && q.bufs[1].abt;
    endproperty
    a_abort_idle: assert property (p_abort_idle) else $error("abort not taken"); // R4

    property p_arb;
        q.st == ST_BUSY && !i_tx_ok && i_tx_arb_lost |=> q.bufs[$past(q.cur)].larb;
    endproperty
    a_arb: assert property (p_arb) else $error("lost arbitration not flagged"); // R6

    property p_legacy_irq;
        i_psel && !i_penable && i_paddr == 12'h000 && !q.enh |=> o_prdata[B_IRQ] == 1'b0;
    endproperty
    a_legacy_irq: assert property (p_legacy_irq) else $error("done flag read in legacy"); // R8

    property p_overflow;
        i_tec_inc && q.tec > (8'hff - TEC_STEP) |=> o_bus_off && o_tec == 8'hff;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow missed bus off"); // R18

    property p_recover;
        q.bus_off && i_rec11 && q.rec_cnt == REC_OCC - 8'h01 && !i_tec_inc
            |=> o_tec == 8'h00 && !o_bus_off;
    endproperty
    a_recover: assert property (p_recover) else $error("counter not cleared"); // R19

    property p_tie;
        q.st == ST_IDLE && !q.bus_off && pick[2] && d.bufs[2].req && !d.bufs[2].abt_pend
            && d.bufs[2].pri == 2'h3 |=> q.cur == 2'h2 ##1 o_tx_valid;
    endproperty
    a_tie: assert property (p_tie) else $error("wrong buffer chosen"); // R22

    property p_err;
        q.st == ST_BUSY && !i_tx_ok && i_tx_bus_err |=> q.bufs[$past(q.cur)].err;
    endproperty
    a_err: assert property (p_err) else $error("bus error not flagged"); // R7

    property p_abort_late;
        q.st == ST_BUSY && !i_tx_ok && (i_tx_arb_lost || i_tx_bus_err) && q.bufs[q.cur].abt_pend
            |=> !q.bufs[$past(q.cur)].req && q.bufs[$past(q.cur)].abt;
    endproperty
    a_abort_late: assert property (p_abort_late) else $error("late abort not taken"); // R5

    property p_tec_dec;
        i_tec_dec && !i_tec_inc && q.tec != 8'h00 && !q.bus_off |=> o_tec == $past(q.tec) - 8'h01;
    endproperty
    a_tec_dec: assert property (p_tec_dec) else $error("counter did not step down"); // R18

    property p_offline;
        q.bus_off && q.st == ST_IDLE |=> !o_tx_valid;
    endproperty
    a_offline: assert property (p_offline) else $error("frame offered in bus off"); // R18

endmodule : ctb_tx_bank
`default_nettype wire

// ==== ctb_pkg.sv ====
// shared constants and types of the transmit buffer bank
package ctb_pkg;

    localparam int NBUF = 3;
    localparam int NDATA = 8;
    localparam int AW = 12;

    // buffer n sits at byte n*0x40, word index within a buffer below
    localparam logic [3:0] W_CTRL = 4'h0;
    localparam logic [3:0] W_SIDH = 4'h1;
    localparam logic [3:0] W_SIDL = 4'h2;
    localparam logic [3:0] W_EIDH = 4'h3;
    localparam logic [3:0] W_EIDL = 4'h4;
    localparam logic [3:0] W_DLC = 4'h5;
    localparam logic [3:0] W_DATA0 = 4'h8;
    // global block in slot 3 (byte 0x0c0)
    localparam logic [1:0] GLOB_SLOT = 2'h3;
    localparam logic [3:0] W_TEC = 4'h0;
    localparam logic [3:0] W_CFG = 4'h1;
    localparam logic [3:0] W_STAT = 4'h2;

    localparam int B_IRQ = 7;
    localparam int B_ABT = 6;
    localparam int B_LARB = 5;
    localparam int B_ERR = 4;
    localparam int B_REQ = 3;
    localparam int B_EXT = 3;
    localparam int B_RTR = 6;
    localparam int B_ENH = 0;
    localparam int B_BOFF = 0;
    localparam logic [7:0] SIDL_MASK = 8'heb;
    localparam logic [7:0] DLC_MASK = 8'h4f;

    localparam logic [7:0] TEC_STEP_DEF = 8'h08;
    localparam logic [7:0] REC_CLEAR_CNT = 8'h80;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_OFFER = 3'b010,
        ST_BUSY = 3'b100
    } ctb_st_t;

    typedef struct packed {
        logic [28:0] id;
        logic ext;
        logic rtr;
        logic [3:0] dlc;
        logic [NDATA-1:0][7:0] data;
    } ctb_frame_t;

    typedef struct packed {
        logic irq;
        logic abt;
        logic larb;
        logic err;
        logic req;
        logic abt_pend;
        logic [1:0] pri;
        logic [7:0] sidh;
        logic [7:0] sidl;
        logic [7:0] eidh;
        logic [7:0] eidl;
        logic [7:0] dlc;
        logic [NDATA-1:0][7:0] data;
    } ctb_buf_t;

    typedef struct packed {
        ctb_buf_t [NBUF-1:0] bufs;
        ctb_st_t st;
        logic [1:0] cur;
        logic [7:0] tec;
        logic bus_off;
        logic [7:0] rec_cnt;
        logic enh;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic tx_valid;
        logic tx_abort;
        ctb_frame_t frame;
    } ctb_state_t;

endpackage : ctb_pkg

// ==== ctb_engine_model.sv ====
// behavioural protocol engine that takes frames from the buffer bank
`timescale 1ns/100ps
`default_nettype none

module ctb_engine_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [1:0] i_fail,
    input wire logic [7:0] i_dly,
    output logic o_start,
    output logic o_ok,
    output logic o_arb,
    output logic o_err
);
    logic busy_q;
    logic used_q;
    logic [7:0] cnt_q;

    always_ff @(posedge i_clk) begin
        o_start <= 1'b0;
        o_ok <= 1'b0;
        o_arb <= 1'b0;
        o_err <= 1'b0;
        if (i_fail == 2'h0) begin
            used_q <= 1'b0;
        end
        if (i_rst) begin
            busy_q <= 1'b0;
            used_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (!busy_q) begin
            // take an offered frame, only while it is offered
            if (i_valid) begin
                o_start <= 1'b1;
                busy_q <= 1'b1;
                cnt_q <= i_dly;
            end
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else begin
            // one end pulse per attempt, one failure per setting
            busy_q <= 1'b0;
            if (i_fail == 2'h1 && !used_q) begin
                o_arb <= 1'b1;
                used_q <= 1'b1;
            end else if (i_fail == 2'h2 && !used_q) begin
                o_err <= 1'b1;
                used_q <= 1'b1;
            end else begin
                o_ok <= 1'b1;
            end
        end
    end
endmodule : ctb_engine_model
`default_nettype wire

// ==== ctb_tx_bank_bench.sv ====
// self-checking bench of the transmit buffer bank
`timescale 1ns/100ps
`default_nettype none

module ctb_tx_bank_bench;
    import ctb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [AW-1:0] pad = '0;
    logic [31:0] pwd = '0;
    logic prdy, perr, tvld, tabt, boff, st, ok, arb, err;
    logic [31:0] prd;
    ctb_frame_t frm, lf;
    logic [1:0] tbuf;
    logic [2:0] ev = 3'h0;
    logic [1:0] fail = 2'h0;
    logic [7:0] dly = 8'h1e;
    logic [7:0] tec;
    logic [1:0] ord_q[$];
    int miscompares = 0;
    int cmp_count = 0;
    localparam int GBASE = int'(GLOB_SLOT);

    always #2.5 clk = ~clk;

    ctb_tx_bank #(.TEC_STEP(8'h40), .REC_OCC(8'h04)) dut (.i_clk(clk), .i_rst(rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pad), .i_pwdata(pwd),
        .i_pstrb(4'hf), .o_pready(prdy), .o_prdata(prd), .o_pslverr(perr),
        .o_tx_valid(tvld), .o_tx_frame(frm), .o_tx_buf(tbuf), .o_tx_abort(tabt),
        .i_tx_start(st), .i_tx_ok(ok), .i_tx_arb_lost(arb), .i_tx_bus_err(err),
        .i_tec_inc(ev[0]), .i_tec_dec(ev[1]), .i_rec11(ev[2]), .o_bus_off(boff), .o_tec(tec));

    ctb_engine_model eng (.i_clk(clk), .i_rst(rst), .i_valid(tvld), .i_fail(fail),
        .i_dly(dly), .o_start(st), .o_ok(ok), .o_arb(arb), .o_err(err));

    always @(posedge clk) begin
        if (st === 1'b1 && tvld === 1'b1) begin
            ord_q.push_back(tbuf);
            lf <= frm;
        end
    end

    function automatic logic [AW-1:0] ad(input int b, input logic [3:0] w);
        return {4'h0, b[1:0], w, 2'b00};
    endfunction : ad

    task automatic conclude;
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) miscompares++;
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdc(input logic [AW-1:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, {24'h0, x});
    endtask : rdc

    task automatic wait_done(input logic [1:0] b);
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        r = 32'h8;
        while (r[B_REQ] !== 1'b0 && n < 300) begin
            apb(1'b0, ad(b, W_CTRL), 8'h00, r, e);
            n++;
        end
        if (n == 300) miscompares++;
    endtask : wait_done

    task automatic wait_starts(input int k);
        int n;
        n = 0;
        while (ord_q.size() < k && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n == 500) miscompares++;
        @(posedge clk);
    endtask : wait_starts

    task automatic pulse(input logic [2:0] v, input int k);
        repeat (k) begin
            ev <= v;
            @(posedge clk);
            ev <= 3'h0;
            @(posedge clk);
        end
    endtask : pulse

    initial begin
        logic [31:0] r;
        logic e;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int b = 0; b < NBUF; b++) rdc(ad(b, W_CTRL), 8'h00);
        rdc(ad(GBASE, W_TEC), 8'h00);
        wr(ad(0, W_CTRL), 8'h07);
        rdc(ad(0, W_CTRL), 8'h03);
        wr(ad(0, W_SIDL), 8'hff);
        rdc(ad(0, W_SIDL), 8'heb);
        wr(ad(0, W_DLC), 8'hff);
        rdc(ad(0, W_DLC), 8'h4f);
        apb(1'b0, 12'h100, 8'h00, r, e);
        chk({31'h0, e}, 32'h1);
        wr(ad(1, W_SIDH), 8'ha5);
        wr(ad(1, W_SIDL), 8'hab);
        wr(ad(1, W_EIDH), 8'h3c);
        wr(ad(1, W_EIDL), 8'h5a);
        wr(ad(1, W_DLC), 8'h48);
        for (int m = 0; m < NDATA; m++) wr(ad(1, W_DATA0 + 4'(m)), 8'h10 + 8'(m));
        wr(ad(1, W_CTRL), 8'h0b);
        wait_starts(1);
        chk({3'h0, lf.id}, {3'h0, 8'ha5, 3'b101, 2'b11, 8'h3c, 8'h5a});
        chk({29'h0, lf.ext, lf.rtr, 1'b0}, 32'h6);
        chk({28'h0, lf.dlc}, 32'h8);
        for (int m = 0; m < NDATA; m++) chk({24'h0, lf.data[m]}, 32'h10 + m);
        wr(ad(1, W_SIDH), 8'h00);
        rdc(ad(1, W_SIDH), 8'ha5);
        wait_done(1);
        rdc(ad(1, W_CTRL), 8'h03);
        wr(ad(0, W_SIDH), 8'h24);
        wr(ad(0, W_SIDL), 8'h63);
        wr(ad(0, W_EIDH), 8'hff);
        wr(ad(0, W_DLC), 8'h02);
        wr(ad(0, W_CTRL), 8'h08);
        wait_starts(2);
        chk({3'h0, lf.id}, 32'h123);
        chk({28'h0, lf.ext, lf.rtr, lf.dlc[1:0]}, 32'h2);
        wr(ad(1, W_CTRL), 8'h0a);
        wr(ad(2, W_CTRL), 8'h09);
        wait_starts(4);
        chk({30'h0, ord_q[2]}, 32'h1);
        chk({30'h0, ord_q[3]}, 32'h2);
        wait_done(2);
        wr(ad(0, W_CTRL), 8'h08);
        wait_starts(5);
        wr(ad(1, W_CTRL), 8'h0b);
        wr(ad(2, W_CTRL), 8'h0b);
        wait_starts(7);
        chk({30'h0, ord_q[5], ord_q[6]}, 32'h9);
        wait_done(1);
        wr(ad(GBASE, W_CFG), 8'h01);
        wr(ad(0, W_CTRL), 8'h08);
        wait_starts(8);
        wr(ad(1, W_CTRL), 8'h08);
        wr(ad(1, W_CTRL), 8'h00);
        rdc(ad(1, W_CTRL), 8'h40);
        wait_done(0);
        rdc(ad(0, W_CTRL), 8'h80);
        wr(ad(0, W_CTRL), 8'h00);
        rdc(ad(0, W_CTRL), 8'h00);
        dly <= 8'h02;
        fail <= 2'h1;
        wr(ad(2, W_CTRL), 8'h00);
        wr(ad(2, W_CTRL), 8'h08);
        wait_done(2);
        rdc(ad(2, W_CTRL), 8'ha0);
        fail <= 2'h0;
        wr(ad(2, W_CTRL), 8'h00);
        fail <= 2'h2;
        wr(ad(2, W_CTRL), 8'h08);
        wait_done(2);
        rdc(ad(2, W_CTRL), 8'h90);
        fail <= 2'h0;
        dly <= 8'h1e;
        wr(ad(2, W_CTRL), 8'h00);
        fail <= 2'h1;
        wr(ad(2, W_CTRL), 8'h08);
        wait_starts(13);
        wr(ad(2, W_CTRL), 8'h00);
        chk({31'h0, tabt}, 32'h1);
        wait_done(2);
        rdc(ad(2, W_CTRL), 8'h60);
        pulse(3'h1, 3);
        rdc(ad(GBASE, W_TEC), 8'hc0);
        pulse(3'h2, 1);
        wr(ad(GBASE, W_TEC), 8'h00);
        rdc(ad(GBASE, W_TEC), 8'hbf);
        pulse(3'h1, 2);
        chk({31'h0, boff}, 32'h1);
        chk({24'h0, tec}, 32'hff);
        rdc(ad(GBASE, W_STAT), 8'h01);
        pulse(3'h4, 4);
        rdc(ad(GBASE, W_TEC), 8'h00);
        rdc(ad(GBASE, W_STAT), 8'h00);
        conclude();
    end

    initial begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule : ctb_tx_bank_bench
`default_nettype wire
